// [hdl/mprs_port_role_switch.sv]
`timescale 1ns/1ps
// Contract
// - transmit nibble: out in MAC, in in PHY
// - transmit enable marks valid transmit nibble
// - receive valid marks valid receive nibble
// - receive error: input MAC, low PHY
// - MAC mode transmit error held low
// - PHY mode transmit error aborts packet
// - collision: sampled MAC, generated PHY
// - carrier sense: sampled MAC, generated PHY
// - transmit clock: input MAC, output PHY
// - receive clock: input MAC, output PHY
// - receive nibble: in MAC, out PHY
// - slave modes: management data bidirectional
// - master mode: switch masters management data
// - management clock: input slave, output master
module mprs_port_role_switch
(
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      role_phy_i,
  input  wire logic                      mgmt_master_i,
  input  wire logic [mprs_pkg::NIB_W-1:0] sw_tx_data_i,
  input  wire logic                      sw_tx_valid_i,
  output logic                           sw_tx_ready_o,
  output logic [mprs_pkg::NIB_W-1:0]      sw_rx_data_o,
  output logic                           sw_rx_valid_o,
  output logic                           sw_rx_err_o,
  output logic                           sw_rx_end_o,
  output logic                           sw_rx_abort_o,
  output logic                           sw_col_o,
  output logic                           sw_crs_o,
  input  wire logic                      mgmt_mdio_out_i,
  input  wire logic                      mgmt_mdio_oe_i,
  output logic                           mgmt_mdio_in_o,
  output logic                           mgmt_mdc_rise_o,
  input  wire logic [mprs_pkg::NIB_W-1:0] txd_i,
  output logic [mprs_pkg::NIB_W-1:0]      txd_o,
  output logic [mprs_pkg::NIB_W-1:0]      txd_oe_o,
  input  wire logic                      tx_en_i,
  output logic                           tx_en_o,
  output logic                           tx_en_oe_o,
  input  wire logic                      tx_er_i,
  output logic                           tx_er_o,
  output logic                           tx_er_oe_o,
  input  wire logic [mprs_pkg::NIB_W-1:0] rxd_i,
  output logic [mprs_pkg::NIB_W-1:0]      rxd_o,
  output logic [mprs_pkg::NIB_W-1:0]      rxd_oe_o,
  input  wire logic                      rx_dv_i,
  output logic                           rx_dv_o,
  output logic                           rx_dv_oe_o,
  input  wire logic                      rx_er_i,
  output logic                           rx_er_o,
  output logic                           rx_er_oe_o,
  input  wire logic                      col_i,
  output logic                           col_o,
  output logic                           col_oe_o,
  input  wire logic                      crs_i,
  output logic                           crs_o,
  output logic                           crs_oe_o,
  input  wire logic                      tx_clk_i,
  output logic                           tx_clk_o,
  output logic                           tx_clk_oe_o,
  input  wire logic                      rx_clk_i,
  output logic                           rx_clk_o,
  output logic                           rx_clk_oe_o,
  input  wire logic                      mdio_i,
  output logic                           mdio_o,
  output logic                           mdio_oe_o,
  input  wire logic                      mdc_i,
  output logic                           mdc_o,
  output logic                           mdc_oe_o
);
  import mprs_pkg::*;

  mprs_edge_if tx_edge ();
  mprs_edge_if rx_edge ();
  mprs_edge_if mdc_edge ();

  logic              phy_reg,      phy_next;
  logic              master_reg,   master_next;
  logic [SY_W-1:0]   sy1_reg,      sy1_next;
  logic [SY_W-1:0]   sy2_reg,      sy2_next;
  logic [NIB_W-1:0]  snd_data_reg, snd_data_next;
  logic              snd_en_reg,   snd_en_next;
  logic              crs_reg,      crs_next;
  logic              col_reg,      col_next;
  mprs_rx_state_type rx_state_reg, rx_state_next;
  logic [NIB_W-1:0]  rx_data_reg,  rx_data_next;
  logic              rx_valid_reg, rx_valid_next;
  logic              rx_err_reg,   rx_err_next;
  logic              rx_end_reg,   rx_end_next;
  logic              rx_abort_reg, rx_abort_next;
  logic              snd_go;
  logic              rcv_go;
  logic              in_en;
  logic              in_er;
  logic              in_abort;
  logic [NIB_W-1:0]  in_data;

  // clock pins: link clocks generated in PHY role, sampled in MAC role; management clock generated in master mode, sampled in slave mode
  mprs_link_clock #(.HALF_CYC(LINK_HALF_CYC)) u_tx_clk
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .gen_i      (phy_reg),
    .pin_i      (tx_clk_i),
    .edge_o     (tx_edge)
  );

  mprs_link_clock #(.HALF_CYC(LINK_HALF_CYC)) u_rx_clk
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .gen_i      (phy_reg),
    .pin_i      (rx_clk_i),
    .edge_o     (rx_edge)
  );

  mprs_link_clock #(.HALF_CYC(MGMT_HALF_CYC)) u_mdc
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .gen_i      (master_reg),
    .pin_i      (mdc_i),
    .edge_o     (mdc_edge)
  );

  // role selection of the active clock edges
  assign snd_go   = phy_reg ? rx_edge.drive : tx_edge.drive;
  assign rcv_go   = phy_reg ? tx_edge.sample : rx_edge.sample;
  assign in_en    = phy_reg ? sy2_reg[SY_TXEN] : sy2_reg[SY_RXDV];
  assign in_er    = phy_reg ? sy2_reg[SY_TXER] : sy2_reg[SY_RXER];
  assign in_data  = phy_reg ? sy2_reg[SY_TXD +: NIB_W] : sy2_reg[SY_RXD +: NIB_W];
  assign in_abort = phy_reg & in_er;

  always_comb
  begin
    phy_next      = role_phy_i;
    master_next   = mgmt_master_i;
    sy1_next      = {mdio_i, crs_i, col_i, rx_er_i, rx_dv_i, rxd_i, tx_er_i, tx_en_i, txd_i};
    sy2_next      = sy1_reg;
    snd_data_next = snd_data_reg;
    snd_en_next   = snd_en_reg;
    crs_next      = crs_reg;
    col_next      = col_reg;
    if (snd_go)
    begin
      snd_en_next   = sw_tx_valid_i;
      snd_data_next = sw_tx_valid_i ? sw_tx_data_i : NIB_RST;
      crs_next      = sw_tx_valid_i | in_en;
      col_next      = sw_tx_valid_i & in_en;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      phy_reg      <= 1'b0;
      master_reg   <= 1'b0;
      sy1_reg      <= SYNC_RST;
      sy2_reg      <= SYNC_RST;
      snd_data_reg <= NIB_RST;
      snd_en_reg   <= 1'b0;
      crs_reg      <= 1'b0;
      col_reg      <= 1'b0;
    end
    else
    begin
      phy_reg      <= phy_next;
      master_reg   <= master_next;
      sy1_reg      <= sy1_next;
      sy2_reg      <= sy2_next;
      snd_data_reg <= snd_data_next;
      snd_en_reg   <= snd_en_next;
      crs_reg      <= crs_next;
      col_reg      <= col_next;
    end
  end

  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_data_next  = rx_data_reg;
    rx_valid_next = 1'b0;
    rx_err_next   = rx_err_reg;
    rx_end_next   = 1'b0;
    rx_abort_next = 1'b0;
    if (rcv_go)
    begin
      unique case (rx_state_reg)
        RX_IDLE:
        begin
          if (in_en && in_abort)
          begin
            rx_abort_next = 1'b1;
            rx_state_next = RX_DROP;
          end
          else if (in_en)
          begin
            rx_valid_next = 1'b1;
            rx_data_next  = in_data;
            rx_err_next   = ~phy_reg & in_er;
            rx_state_next = RX_FRAME;
          end
        end
        RX_FRAME:
        begin
          if (!in_en)
          begin
            rx_end_next   = 1'b1;
            rx_state_next = RX_IDLE;
          end
          else if (in_abort)
          begin
            rx_abort_next = 1'b1;
            rx_state_next = RX_DROP;
          end
          else
          begin
            rx_valid_next = 1'b1;
            rx_data_next  = in_data;
            rx_err_next   = ~phy_reg & in_er;
          end
        end
        RX_DROP:
        begin
          if (!in_en)
          begin
            rx_state_next = RX_IDLE;
          end
        end
        default:
        begin
          rx_state_next = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rx_state_reg <= RX_IDLE;
      rx_data_reg  <= NIB_RST;
      rx_valid_reg <= 1'b0;
      rx_err_reg   <= 1'b0;
      rx_end_reg   <= 1'b0;
      rx_abort_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_data_reg  <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
      rx_err_reg   <= rx_err_next;
      rx_end_reg   <= rx_end_next;
      rx_abort_reg <= rx_abort_next;
    end
  end

  assign sw_tx_ready_o   = snd_go;
  assign sw_rx_data_o    = rx_data_reg;
  assign sw_rx_valid_o   = rx_valid_reg;
  assign sw_rx_err_o     = rx_err_reg;
  assign sw_rx_end_o     = rx_end_reg;
  assign sw_rx_abort_o   = rx_abort_reg;
  assign sw_col_o        = phy_reg ? col_reg : sy2_reg[SY_COL];
  assign sw_crs_o        = phy_reg ? crs_reg : sy2_reg[SY_CRS];
  assign mgmt_mdio_in_o  = sy2_reg[SY_MDIO];
  assign mgmt_mdc_rise_o = mdc_edge.sample;

  assign txd_o       = snd_data_reg;
  assign txd_oe_o    = phy_reg ? NIB_RST : NIB_ALL;
  assign tx_en_o     = snd_en_reg;
  assign tx_en_oe_o  = ~phy_reg;
  assign tx_er_o     = 1'b0;
  assign tx_er_oe_o  = ~phy_reg;
  assign rxd_o       = snd_data_reg;
  assign rxd_oe_o    = phy_reg ? NIB_ALL : NIB_RST;
  assign rx_dv_o     = snd_en_reg;
  assign rx_dv_oe_o  = phy_reg;
  assign rx_er_o     = 1'b0;
  assign rx_er_oe_o  = phy_reg;
  assign col_o       = col_reg;
  assign col_oe_o    = phy_reg;
  assign crs_o       = crs_reg;
  assign crs_oe_o    = phy_reg;
  assign tx_clk_o    = tx_edge.clk_lvl;
  assign tx_clk_oe_o = phy_reg;
  assign rx_clk_o    = rx_edge.clk_lvl;
  assign rx_clk_oe_o = phy_reg;
  assign mdio_o      = mgmt_mdio_out_i;
  assign mdio_oe_o   = mgmt_mdio_oe_i;
  assign mdc_o       = mdc_edge.clk_lvl;
  assign mdc_oe_o    = master_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_TXD_MAC: assert property (!phy_reg && $changed(txd_o) |-> $past(tx_edge.drive))
    else $error("transmit nibble changed off the transmit clock edge");
  AST_TXEN_VALID: assert property (snd_go && !sw_tx_valid_i |=>
    !tx_en_o && txd_o == NIB_RST) else $error("transmit enable without valid nibble");
  AST_RXDV_PHY: assert property (phy_reg && snd_go && sw_tx_valid_i |=>
    rx_dv_o && rxd_o == $past(sw_tx_data_i)) else $error("receive nibble mismatch");
  AST_RXER_LOW: assert property (phy_reg |-> rx_er_oe_o && !rx_er_o)
    else $error("receive error not driven low in PHY role");
  AST_TXER_LOW: assert property (!phy_reg |-> tx_er_oe_o && !tx_er_o && !rx_er_oe_o)
    else $error("transmit error not driven low in MAC role");
  AST_ABORT: assert property (rcv_go && rx_state_reg == RX_FRAME && in_en && in_abort |=>
    sw_rx_abort_o && !sw_rx_valid_o ##1 !sw_rx_valid_o) else $error("packet not aborted");
  AST_COL_PHY: assert property (phy_reg && col_o |-> crs_o && col_oe_o)
    else $error("collision without carrier in PHY role");
  AST_CRS_MAC: assert property (!phy_reg |-> !crs_oe_o && !col_oe_o)
    else $error("carrier or collision driven in MAC role");
  AST_TXCLK_HALF: assert property (phy_reg && $past(phy_reg) && $rose(tx_clk_o) |->
    tx_clk_o [*4] ##1 !tx_clk_o) else $error("generated transmit clock half period wrong");
  AST_RXCLK_MAC: assert property (!phy_reg |-> !rx_clk_oe_o && !tx_clk_oe_o)
    else $error("clock driven in MAC role");
  AST_RXD_DIR: assert property (phy_reg |-> rxd_oe_o == NIB_ALL && txd_oe_o == NIB_RST)
    else $error("receive nibble direction wrong in PHY role");
  AST_MDC_MASTER: assert property (master_reg && $past(master_reg) && $rose(mdc_o) |->
    mdc_o [*4] ##1 !mdc_o) else $error("management clock half period wrong");
  AST_MDC_SLAVE: assert property (!master_reg |-> !mdc_oe_o && !mdc_o)
    else $error("management clock driven in slave role");
  AST_PHY_TIMING: assert property (phy_reg && $changed(rxd_o) |-> $fell(rx_clk_o))
    else $error("receive nibble changed off generated clock fall");
  COV_PHY_SEND: cover property (phy_reg && snd_go && sw_tx_valid_i);
  COV_MAC_RECV: cover property (!phy_reg && sw_rx_valid_o ##[1:20] sw_rx_end_o);
  COV_ABORT: cover property (phy_reg && sw_rx_abort_o);
  COV_MDC: cover property (master_reg && mgmt_mdc_rise_o);

endmodule // mprs_port_role_switch

// [hdl/mprs_pkg.sv]
package mprs_pkg;

  // core clock and link clock timing
  localparam int unsigned CORE_PERIOD_NS = 50;
  localparam int unsigned LINK_PERIOD_NS = 400;
  localparam int unsigned MGMT_PERIOD_NS = 400;
  localparam int unsigned LINK_HALF_CYC  =
    (LINK_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned MGMT_HALF_CYC  =
    (MGMT_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned DIV_W          = 8;
  localparam int unsigned DLY_W          = 2;

  // nibble width
  localparam int unsigned NIB_W = 4;

  // positions in the pin synchroniser vector
  localparam int unsigned SY_TXD  = 0;
  localparam int unsigned SY_TXEN = 4;
  localparam int unsigned SY_TXER = 5;
  localparam int unsigned SY_RXD  = 6;
  localparam int unsigned SY_RXDV = 10;
  localparam int unsigned SY_RXER = 11;
  localparam int unsigned SY_COL  = 12;
  localparam int unsigned SY_CRS  = 13;
  localparam int unsigned SY_MDIO = 14;
  localparam int unsigned SY_W    = 15;

  // reset values and the all-ones nibble
  localparam logic [NIB_W-1:0] NIB_RST  = 4'h0;
  localparam logic [NIB_W-1:0] NIB_ALL  = 4'hf;
  localparam logic [SY_W-1:0]  SYNC_RST = 15'h0000;
  localparam logic [DIV_W-1:0] DIV_RST  = 8'h00;
  localparam logic [DLY_W-1:0] DLY_RST  = 2'h0;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_FRAME,
    RX_DROP
  } mprs_rx_state_type;

endpackage

// [hdl/mprs_edge_if.sv]
`timescale 1ns/1ps
interface mprs_edge_if;
  logic clk_lvl;
  logic drive;
  logic sample;

  modport gen
  (
    output clk_lvl,
    output drive,
    output sample
  );

  modport sink
  (
    input clk_lvl,
    input drive,
    input sample
  );
endinterface

// [hdl/mprs_link_clock.sv]
`timescale 1ns/1ps
module mprs_link_clock
#(
  parameter int unsigned HALF_CYC = mprs_pkg::LINK_HALF_CYC
)
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic gen_i,
  input  wire logic pin_i,
  mprs_edge_if.gen  edge_o
);
  import mprs_pkg::*;

  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);

  logic             sync1_reg,    sync1_next;
  logic             sync2_reg,    sync2_next;
  logic             sync3_reg,    sync3_next;
  logic [DIV_W-1:0] cnt_reg,      cnt_next;
  logic             gclk_reg,     gclk_next;
  logic [DLY_W-1:0] fdly_reg,     fdly_next;
  logic             wrap;
  logic             gfall;
  logic             prise;

  always_comb
  begin
    sync1_next = pin_i;
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    wrap       = (cnt_reg == HALF_LAST);
    gfall      = gen_i & gclk_reg & wrap;
    prise      = sync2_reg & ~sync3_reg;
    cnt_next   = DIV_RST;
    gclk_next  = 1'b0;
    if (gen_i)
    begin
      cnt_next  = wrap ? DIV_RST : cnt_reg + 1'b1;
      gclk_next = wrap ? ~gclk_reg : gclk_reg;
    end
    fdly_next = {fdly_reg[0], gfall};
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      cnt_reg   <= DIV_RST;
      gclk_reg  <= 1'b0;
      fdly_reg  <= DLY_RST;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      cnt_reg   <= cnt_next;
      gclk_reg  <= gclk_next;
      fdly_reg  <= fdly_next;
    end
  end

  // generated: drive on falling edge, sample two core cycles after the fall; received: both on rise
  assign edge_o.clk_lvl = gclk_reg;
  assign edge_o.drive   = gen_i ? gfall : prise;
  assign edge_o.sample  = gen_i ? fdly_reg[1] : prise;

endmodule // mprs_link_clock

// [tb/mprs_far_model.sv]
`timescale 1ns/1ps
module mprs_far_model
(
  input  wire logic       phy_role_i,
  input  wire logic       run_i,
  input  wire logic       tx_clk_w_i,
  input  wire logic       rx_clk_w_i,
  input  wire logic [3:0] txd_w_i,
  input  wire logic       tx_en_w_i,
  input  wire logic [3:0] rxd_w_i,
  input  wire logic       rx_dv_w_i,
  output logic            tx_clk_o,
  output logic            rx_clk_o,
  output logic [3:0]      txd_o,
  output logic            tx_en_o,
  output logic            tx_er_o,
  output logic [3:0]      rxd_o,
  output logic            rx_dv_o,
  output logic            rx_er_o,
  output logic            col_o,
  output logic            crs_o
);
  logic [3:0] seen_q[$];

  initial
  begin
    {tx_clk_o, rx_clk_o, tx_en_o, tx_er_o, rx_dv_o, rx_er_o, col_o, crs_o} = 8'h00;
    txd_o = 4'h0;
    rxd_o = 4'h0;
  end

  // phy side clocks, stopped while run is low
  always #200 tx_clk_o = run_i & ~tx_clk_o;
  initial #73 forever #200 rx_clk_o = run_i & ~rx_clk_o;

  // far end capture of what the switch sends
  always @(posedge (phy_role_i ? rx_clk_w_i : tx_clk_o))
    if (phy_role_i ? rx_dv_w_i : tx_en_w_i)
      seen_q.push_back(phy_role_i ? rxd_w_i : txd_w_i);

  task automatic step;
    if (phy_role_i)
      @(posedge tx_clk_w_i);
    else
      @(negedge rx_clk_o);
  endtask

  // one frame toward the switch
  task automatic send(input logic [3:0] nib[$], input int err_at, input logic col);
    for (int i = 0; i < nib.size(); i++)
    begin
      step();
      if (phy_role_i)
      begin
        txd_o <= nib[i];
        tx_en_o <= 1'b1;
        tx_er_o <= (i == err_at);
      end
      else
      begin
        rxd_o <= nib[i];
        rx_dv_o <= 1'b1;
        rx_er_o <= (i == err_at);
        crs_o <= 1'b1;
        col_o <= col;
      end
    end
    step();
    {tx_en_o, tx_er_o, rx_dv_o, rx_er_o, col_o, crs_o} <= 6'h00;
    txd_o <= ~txd_o;
    rxd_o <= ~rxd_o;
  endtask
endmodule // mprs_far_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import mprs_pkg::*;
  logic core_clk_i, rst_i, role_phy_i, mgmt_master_i, sw_tx_valid_i, sw_tx_ready_o;
  logic sw_rx_valid_o, sw_rx_err_o, sw_rx_end_o, sw_rx_abort_o, sw_col_o, sw_crs_o;
  logic mgmt_mdio_out_i, mgmt_mdio_oe_i, mgmt_mdio_in_o, mgmt_mdc_rise_o;
  logic tx_en_i, tx_en_o, tx_en_oe_o, tx_er_i, tx_er_o, tx_er_oe_o;
  logic rx_dv_i, rx_dv_o, rx_dv_oe_o, rx_er_i, rx_er_o, rx_er_oe_o;
  logic col_i, col_o, col_oe_o, crs_i, crs_o, crs_oe_o;
  logic tx_clk_i, tx_clk_o, tx_clk_oe_o, rx_clk_i, rx_clk_o, rx_clk_oe_o;
  logic mdio_i, mdio_o, mdio_oe_o, mdc_i, mdc_o, mdc_oe_o;
  logic [NIB_W-1:0] sw_tx_data_i, sw_rx_data_o, txd_i, txd_o, txd_oe_o, rxd_i, rxd_o, rxd_oe_o;
  logic run, bus_mdc, bus_mdio, bus_mdio_oe;
  logic f_txc, f_rxc, f_tx_en, f_tx_er, f_rx_dv, f_rx_er, f_col, f_crs;
  logic [3:0] f_txd, f_rxd;
  int num_errors, num_checks;

  // wire levels: switch where enabled, else far side
  assign txd_i = (txd_oe_o & txd_o) | (~txd_oe_o & f_txd);
  assign rxd_i = (rxd_oe_o & rxd_o) | (~rxd_oe_o & f_rxd);
  assign tx_en_i = tx_en_oe_o ? tx_en_o : f_tx_en;
  assign tx_er_i = tx_er_oe_o ? tx_er_o : f_tx_er;
  assign rx_dv_i = rx_dv_oe_o ? rx_dv_o : f_rx_dv;
  assign rx_er_i = rx_er_oe_o ? rx_er_o : f_rx_er;
  assign col_i = col_oe_o ? col_o : f_col;
  assign crs_i = crs_oe_o ? crs_o : f_crs;
  assign tx_clk_i = tx_clk_oe_o ? tx_clk_o : f_txc;
  assign rx_clk_i = rx_clk_oe_o ? rx_clk_o : f_rxc;
  assign mdc_i = mdc_oe_o ? mdc_o : bus_mdc;
  assign mdio_i = mdio_oe_o ? mdio_o : (bus_mdio_oe ? bus_mdio : 1'b1);

  mprs_port_role_switch mprs_port_role_switch_i (.*);

  mprs_far_model mprs_far_model_i
  (
    .phy_role_i(role_phy_i), .run_i(run), .tx_clk_w_i(tx_clk_i), .rx_clk_w_i(rx_clk_i),
    .txd_w_i(txd_i), .tx_en_w_i(tx_en_i), .rxd_w_i(rxd_i), .rx_dv_w_i(rx_dv_i),
    .tx_clk_o(f_txc), .rx_clk_o(f_rxc), .txd_o(f_txd), .tx_en_o(f_tx_en),
    .tx_er_o(f_tx_er), .rxd_o(f_rxd), .rx_dv_o(f_rx_dv), .rx_er_o(f_rx_er),
    .col_o(f_col), .crs_o(f_crs)
  );

  always #25 core_clk_i = ~core_clk_i;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // enables, fixed-low outputs and generated clocks
  task automatic role_pins;
    int r[4];
    logic [3:0] cur, prev;
    logic p, m;
    p = role_phy_i;
    m = mgmt_master_i;
    check("enables", {txd_oe_o, rxd_oe_o, tx_en_oe_o, tx_er_oe_o, rx_dv_oe_o, rx_er_oe_o},
          {{4{!p}}, {4{p}}, !p, !p, p, p});
    check("pin enables", {col_oe_o, crs_oe_o, tx_clk_oe_o, rx_clk_oe_o, mdc_oe_o},
          {p, p, p, p, m});
    check("error outs", {tx_er_o, rx_er_o}, 2'h0);
    r = '{0, 0, 0, 0};
    prev = {tx_clk_o, rx_clk_o, mdc_o, 1'b0};
    repeat (80)
    begin
      @(posedge core_clk_i);
      cur = {tx_clk_o, rx_clk_o, mdc_o, mgmt_mdc_rise_o};
      for (int k = 0; k < 4; k++)
        r[k] += (cur[k] === 1'b1 && (prev[k] === 1'b0 || k == 0));
      prev = cur;
    end
    check("tx clock rises", r[3], p ? 10 : 0);
    check("rx clock rises", r[2], p ? 10 : 0);
    check("mgmt clock rises", r[1], m ? 10 : 0);
    check("mgmt rise pulses", r[0], m ? 10 : 0);
  endtask

  // user nibbles reach the far side
  task automatic send_path;
    logic [3:0] exp[$];
    int k;
    exp = '{4'h5, 4'ha, 4'h0, 4'hf};
    k = 0;
    mprs_far_model_i.seen_q.delete();
    sw_tx_valid_i <= 1'b1;
    sw_tx_data_i <= exp[0];
    for (int i = 0; i < 200 && k < 4; i++)
    begin
      @(posedge core_clk_i);
      if (sw_tx_ready_o === 1'b1)
      begin
        k++;
        sw_tx_valid_i <= (k < 4);
        sw_tx_data_i <= exp[k % 4];
      end
    end
    if (k < 4)
    begin
      check("ready wait", 0, 1);
      conclude();
    end
    cyc(4);
    check("carrier out", {crs_o & crs_oe_o, col_o & col_oe_o}, {role_phy_i, 1'b0});
    cyc(24);
    check("sent count", mprs_far_model_i.seen_q.size(), 4);
    for (int i = 0; i < 4 && i < mprs_far_model_i.seen_q.size(); i++)
      check("sent nibble", mprs_far_model_i.seen_q[i], exp[i]);
  endtask

  // far side frame reaches the user
  task automatic recv_path(input int err_at, input int exp_n);
    logic [3:0] d[$], got[$];
    logic errs[$];
    int ends, aborts;
    logic [1:0] cs;
    d = '{4'h1, 4'h8, 4'he, 4'h7};
    ends = 0;
    aborts = 0;
    cs = 2'h0;
    fork
      mprs_far_model_i.send(d, err_at, !role_phy_i);
      repeat (120)
      begin
        @(posedge core_clk_i);
        if (sw_rx_valid_o === 1'b1)
        begin
          errs.push_back(sw_rx_err_o);
          got.push_back(sw_rx_data_o);
        end
        ends += (sw_rx_end_o === 1'b1);
        aborts += (sw_rx_abort_o === 1'b1);
        if (got.size() == 1)
          cs = {sw_col_o, sw_crs_o};
      end
    join
    check("received count", got.size(), exp_n);
    for (int i = 0; i < exp_n && i < got.size(); i++)
    begin
      check("received nibble", got[i], d[i]);
      check("receive error", errs[i], !role_phy_i && i == err_at);
    end
    check("end pulses", ends, exp_n == 4);
    check("abort pulses", aborts, exp_n < 4);
    check("col crs", cs, {!role_phy_i, 1'b1});
  endtask

  // slave management pins
  task automatic mgmt_slave;
    int n;
    n = 0;
    bus_mdio_oe <= 1'b1;
    bus_mdio <= 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge core_clk_i);
      bus_mdc <= i[3];
      n += (mgmt_mdc_rise_o === 1'b1);
    end
    check("slave mdc rises", n, 4);
    check("mdio in low", mgmt_mdio_in_o, 1'b0);
    bus_mdio <= 1'b1;
    cyc(4);
    check("mdio in high", mgmt_mdio_in_o, 1'b1);
    bus_mdio_oe <= 1'b0;
    mgmt_mdio_oe_i <= 1'b1;
    mgmt_mdio_out_i <= 1'b0;
    cyc(4);
    check("mdio out", {mdio_oe_o, mdio_o, mgmt_mdio_in_o}, 3'h4);
    mgmt_mdio_oe_i <= 1'b0;
    cyc(4);
    check("mdio released", {mdio_oe_o, mgmt_mdio_in_o}, 2'h1);
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    rst_i = 1'b1;
    {role_phy_i, mgmt_master_i, sw_tx_valid_i, mgmt_mdio_out_i, mgmt_mdio_oe_i} = 5'h00;
    {run, bus_mdc, bus_mdio, bus_mdio_oe} = 4'h2;
    sw_tx_data_i = 4'h0;
    num_errors = 0;
    num_checks = 0;
    cyc(4);
    check("reset enables", {txd_oe_o, tx_en_oe_o, tx_er_oe_o, rxd_oe_o, rx_dv_oe_o,
          tx_clk_oe_o, sw_rx_valid_o}, 13'h1f80);
    cyc(4);
    rst_i <= 1'b0;
    run <= 1'b1;
    cyc(12);
    role_pins();
    send_path();
    recv_path(2, 4);
    mgmt_slave();
    role_phy_i <= 1'b1;
    mgmt_master_i <= 1'b1;
    run <= 1'b0;
    rst_i <= 1'b1;
    cyc(8);
    rst_i <= 1'b0;
    cyc(12);
    role_pins();
    send_path();
    recv_path(-1, 4);
    recv_path(2, 2);
    conclude();
  end

  initial
  begin
    cyc(20000);
    check("run time", 0, 1);
    conclude();
  end
endmodule // tb_top
